// ### pkg/pot_cmd_pkg.sv
// constants for the serial potentiometer command logic
package pot_cmd_pkg;
  localparam int WIPER_W = 6;
  localparam int SETTING_CNT = 4;
  localparam int TAP_CNT = 64;
  localparam logic [5:0] WIPER_MAX = 6'h3F;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [3:0] ID_TYPE_DEFAULT = 4'hA; // arbitrary device-type code
  localparam logic [2:0] ID_FIXED = 3'h6;        // bits 3..1 of the id byte
  localparam logic [3:0] OP_RD_WIPER = 4'h9;
  localparam logic [3:0] OP_WR_WIPER = 4'hA;
  localparam logic [3:0] OP_RD_SET = 4'hB;
  localparam logic [3:0] OP_WR_SET = 4'hC;
  localparam logic [3:0] OP_SET_TO_WIPER = 4'hD;
  localparam logic [3:0] OP_WIPER_TO_SET = 4'hE;
  localparam logic [3:0] OP_INCDEC = 4'h2;
  localparam logic [3:0] OP_STATUS = 4'h5;
  localparam logic [1:0] LOW_BITS_ZERO = 2'h0;
  localparam logic [1:0] LOW_BITS_STATUS = 2'h1;
  localparam int CLK_MHZ = 100;
  localparam int NV_WRITE_TIME_US = 10000;         // longest save time
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;
  localparam int WIPER_SETTLE_NS = 100;            // settle delay after transfer
  localparam int WIPER_SETTLE_CYCLES = (WIPER_SETTLE_NS * CLK_MHZ) / 1000;
  localparam logic [5:0] SETTING_RESET = 6'h00;
endpackage

// ### logic/pot_tap_decoder.sv
// one-hot tap switch decoder for the wiper counter
`timescale 1ns/1ns
`default_nettype none
module pot_tap_decoder #(
  parameter int WIDTH = 6
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] position,
  output logic [(1<<WIDTH)-1:0] tapEnable
);
  typedef struct packed {
    logic [(1<<WIDTH)-1:0] taps;
  } dec_state_t;
  dec_state_t s_q, s_d;

  // exactly one switch closed per position, registered for glitch-free switching
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < (1<<WIDTH); i++) begin
      s_d.taps[i] = (position == WIDTH'(i));
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tapEnable = s_q.taps;
endmodule
`default_nettype wire

// ### logic/pot_cmd_logic.sv
// serial command interpreter and register logic for the 64-tap potentiometer
// What this block does
// RL1 - six-bit wiper counter, loaded serially or parallel, decoded to one of 64 taps
// RL2 - at power-up wiper counter loads from stored setting zero
// RL3 - any setting change finishes its internal write within 10 ms
// RL4 - settings hold six bits in low byte positions, top two read zero
// RL5 - wiper reads back in low six bits, top two bits zero
// RL6 - setting save starts only at chip select rise after complete write
// RL7 - write-busy flag returned in bit zero of the status response
// RL8 - first byte after select falls is id; upper nibble is type code
// RL9 - id bit zero must match address pin to continue
// RL10 - host sets id bits three to one to 110
// RL11 - second byte: 4-bit opcode, 2-bit selector, two low bits zero except for status
// RL12 - decode read/write wiper and read/write setting opcodes
// RL13 - decode both transfers and increment/decrement enable
// RL14 - decode read status as opcode 0101, selector zero, low bit one
// RL15 - transfers are two bytes, no data byte follows
// RL16 - setting to wiper applies after settle delay; reverse is a save
// RL17 - reads, writes and status are three bytes; third byte by reader
// RL18 - during inc/dec, clock with input high steps wiper up
// RL19 - during inc/dec, clock with input low steps wiper down
// RL20 - all four settings readable, writable and transferable both ways
// RL21 - write-protect low blocks setting saves but not wiper writes
// RL22 - input sampled on rising clock, output changed on falling clock
// RL23 - pause pin low suspends the sequence without resetting it
// RL24 - select high deselects, output off; first operation needs select fall
// RL25 - inc/dec saturates at 0 and 63
// RL26 - mismatched id discards the command until select rises
`timescale 1ns/1ns
`default_nettype none
module pot_cmd_logic
  import pot_cmd_pkg::*;
#(
  parameter int NV_CYCLES = NV_WRITE_CYCLES,
  parameter logic [3:0] ID_TYPE = ID_TYPE_DEFAULT // arbitrary value
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic pauseN,
  input wire logic writeProtN,
  input wire logic addrSelectPin,
  output logic serialOut,
  output logic serialOutEnN,
  output logic [pot_cmd_pkg::WIPER_W-1:0] wiperPositionCounter,
  output logic [pot_cmd_pkg::TAP_CNT-1:0] tapEnable,
  output logic writeBusy
);
  import pot_cmd_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ID    = 6'h02,
    ST_INSTR = 6'h04,
    ST_DATA  = 6'h08,
    ST_INCDEC = 6'h10,
    ST_DROP  = 6'h20
  } phase_t;

  typedef enum logic [1:0] {
    PW_LOAD = 2'h1,
    PW_RUN  = 2'h2
  } power_t;

  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] sckSync;
    logic [1:0] siSync;
    logic [1:0] holdSync;
    logic [1:0] wpSync;
    logic [1:0] a0Sync;
    logic sckPrev;
    logic csPrev;
    logic armed;
    power_t power;
    phase_t phase;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic [3:0] opcode;
    logic [1:0] regSel;
    logic [7:0] outByte;
    logic outBit;
    logic outEnN;
    logic [5:0] wiper;
    logic [SETTING_CNT-1:0][5:0] setting;
    logic saveArmed;
    logic [1:0] saveSel;
    logic [5:0] saveVal;
    logic busy;
    logic [31:0] nvCnt;
    logic settlePend;
    logic [15:0] settleCnt;
    logic [5:0] settleVal;
  } core_t;

  core_t s_q, s_d;

  logic csN, sck, si, holdN, wpN, a0;
  logic sckRise, sckFall, csRise, csFall, active;
  logic [7:0] inByte;

  // synchronised pin levels; only the second stage is read
  assign csN = s_q.csSync[1];
  assign sck = s_q.sckSync[1];
  assign si = s_q.siSync[1];
  assign holdN = s_q.holdSync[1];
  assign wpN = s_q.wpSync[1];
  assign a0 = s_q.a0Sync[1];
  assign sckRise = sck && !s_q.sckPrev;
  assign sckFall = !sck && s_q.sckPrev;
  assign csRise = csN && !s_q.csPrev;
  assign csFall = !csN && s_q.csPrev;
  // paused transfers ignore clocks but keep their place
  assign active = !csN && holdN && s_q.armed; // see RL23
  assign inByte = {s_q.shift[6:0], si};

  always_comb begin
    s_d = s_q;
    s_d.csSync = {s_q.csSync[0], chipSelN};
    s_d.sckSync = {s_q.sckSync[0], serialClk};
    s_d.siSync = {s_q.siSync[0], serialIn};
    s_d.holdSync = {s_q.holdSync[0], pauseN};
    s_d.wpSync = {s_q.wpSync[0], writeProtN};
    s_d.a0Sync = {s_q.a0Sync[0], addrSelectPin};
    s_d.sckPrev = sck;
    s_d.csPrev = csN;

    // power-up recall of setting zero into the wiper
    if (s_q.power == PW_LOAD) begin
      s_d.wiper = s_q.setting[0]; // see RL2
      s_d.power = PW_RUN;
    end

    // nonvolatile save timer; busy until the count runs out
    if (s_q.busy) begin
      if (s_q.nvCnt >= 32'(NV_CYCLES - 1)) begin
        s_d.busy = 1'b0; // see RL3
        s_d.setting[s_q.saveSel] = s_q.saveVal;
      end else begin
        s_d.nvCnt = s_q.nvCnt + 32'h1;
      end
    end

    // delayed wiper update after a setting-to-wiper transfer
    if (s_q.settlePend) begin
      if (s_q.settleCnt >= 16'(WIPER_SETTLE_CYCLES - 1)) begin
        s_d.settlePend = 1'b0;
        s_d.wiper = s_q.settleVal; // see RL16
      end else begin
        s_d.settleCnt = s_q.settleCnt + 16'h1;
      end
    end

    // select rising ends the frame and may launch a save
    if (csRise) begin
      s_d.phase = ST_IDLE; // see RL24
      s_d.outEnN = 1'b1;
      if (s_q.saveArmed && !s_q.busy && wpN) begin // protect dropped mid-frame still blocks, see RL21
        s_d.busy = 1'b1; // see RL6
        s_d.nvCnt = 32'h0;
      end
      s_d.saveArmed = 1'b0;
    end else if (csN) begin
      s_d.outEnN = 1'b1; // see RL24
    end

    // first operation needs a falling select after reset
    if (csFall) begin
      s_d.armed = 1'b1; // see RL24
      s_d.phase = ST_ID; // see RL8
      s_d.bitCnt = 3'h0;
      s_d.saveArmed = 1'b0;
    end

    // rising serial clock: sample input
    if (active && sckRise) begin // see RL22
      s_d.shift = inByte;
      s_d.bitCnt = s_q.bitCnt + 3'h1;
      unique case (s_q.phase)
        ST_ID: begin
          if (s_q.bitCnt == 3'h7) begin
            // type nibble, fixed pattern and address bit must all match
            if (inByte[7:4] == ID_TYPE && inByte[3:1] == ID_FIXED && inByte[0] == a0) begin // see RL8 RL9 RL10
              s_d.phase = ST_INSTR;
            end else begin
              s_d.phase = ST_DROP; // see RL26
            end
          end
        end
        ST_INSTR: begin
          if (s_q.bitCnt == 3'h7) begin
            s_d.opcode = inByte[7:4]; // see RL11
            s_d.regSel = inByte[3:2];
            s_d.phase = ST_DATA;
            // unknown byte forms are dropped rather than guessed
            unique case (inByte[7:4])
              OP_RD_WIPER: begin
                s_d.outByte = {2'h0, s_q.wiper}; // see RL5 RL12
                if (inByte[3:0] != 4'h0) s_d.phase = ST_DROP;
              end
              OP_WR_WIPER: begin
                if (inByte[3:0] != 4'h0) s_d.phase = ST_DROP; // see RL12
              end
              OP_RD_SET: begin
                s_d.outByte = {2'h0, s_q.setting[inByte[3:2]]}; // see RL4 RL20
                if (inByte[1:0] != LOW_BITS_ZERO) s_d.phase = ST_DROP;
              end
              OP_WR_SET: begin
                if (inByte[1:0] != LOW_BITS_ZERO) s_d.phase = ST_DROP; // see RL12
              end
              OP_SET_TO_WIPER: begin
                s_d.phase = ST_DROP; // see RL15
                if (inByte[1:0] == LOW_BITS_ZERO) begin
                  s_d.settlePend = 1'b1; // see RL13 RL16
                  s_d.settleCnt = 16'h0;
                  s_d.settleVal = s_q.setting[inByte[3:2]];
                end
              end
              OP_WIPER_TO_SET: begin
                s_d.phase = ST_DROP; // see RL15
                if (inByte[1:0] == LOW_BITS_ZERO && wpN && !s_q.busy) begin // see RL21
                  s_d.saveArmed = 1'b1; // see RL13 RL16
                  s_d.saveSel = inByte[3:2];
                  s_d.saveVal = s_q.wiper;
                end
              end
              OP_INCDEC: begin
                s_d.phase = (inByte[3:0] == 4'h0) ? ST_INCDEC : ST_DROP; // see RL13
              end
              OP_STATUS: begin
                s_d.outByte = {7'h0, s_q.busy}; // see RL7
                if (inByte[3:0] != {2'h0, LOW_BITS_STATUS}) s_d.phase = ST_DROP; // see RL14
              end
              default: begin
                s_d.phase = ST_DROP;
              end
            endcase
          end
        end
        ST_DATA: begin
          if (s_q.bitCnt == 3'h7) begin
            s_d.phase = ST_DROP; // see RL17
            if (s_q.opcode == OP_WR_WIPER) begin
              s_d.wiper = inByte[5:0]; // see RL1 RL21
              s_d.settlePend = 1'b0;
            end else if (s_q.opcode == OP_WR_SET && wpN && !s_q.busy) begin
              s_d.saveArmed = 1'b1; // see RL21 RL20
              s_d.saveSel = s_q.regSel;
              s_d.saveVal = inByte[5:0];
            end
          end
        end
        ST_INCDEC: begin
          if (si) begin
            if (s_q.wiper != WIPER_MAX) s_d.wiper = s_q.wiper + 6'h1; // see RL18 RL25
          end else begin
            if (s_q.wiper != WIPER_MIN) s_d.wiper = s_q.wiper - 6'h1; // see RL19 RL25
          end
          s_d.settlePend = 1'b0;
        end
        ST_IDLE, ST_DROP: begin
          s_d.bitCnt = s_q.bitCnt;
        end
        default: begin
          s_d.phase = ST_DROP;
        end
      endcase
    end

    // falling serial clock: present next bit of a read byte
    if (active && sckFall) begin // see RL22
      if (s_q.phase == ST_DATA && s_q.opcode inside {OP_RD_WIPER, OP_RD_SET, OP_STATUS}) begin
        s_d.outBit = s_q.outByte[3'h7 - s_q.bitCnt]; // see RL17
        s_d.outEnN = 1'b0;
      end else begin
        s_d.outEnN = 1'b1;
      end
    end
  end

  // one register bank for the core state; the tap decoder has its own
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.csSync <= 2'h3;
      s_q.csPrev <= 1'b1;
      s_q.holdSync <= 2'h3;
      s_q.wpSync <= 2'h3;
      s_q.power <= PW_LOAD;
      s_q.phase <= ST_IDLE;
      s_q.outEnN <= 1'b1;
      for (int i = 0; i < SETTING_CNT; i++) begin
        s_q.setting[i] <= SETTING_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // tap switch decode of the counter
  pot_tap_decoder #(
    .WIDTH(WIPER_W)
  ) tapDec (
    .mclk(mclk),
    .resetn(resetn),
    .position(s_q.wiper),
    .tapEnable(tapEnable) // see RL1
  );

  assign serialOut = s_q.outBit;
  assign serialOutEnN = s_q.outEnN;
  assign wiperPositionCounter = s_q.wiper;
  assign writeBusy = s_q.busy;
endmodule
`default_nettype wire

// ### tb/pot_cmd_logic_sva.sv
// port assertions for the potentiometer command logic
`timescale 1ns/1ns
`default_nettype none
module pot_cmd_logic_sva
  import pot_cmd_pkg::*;
#(
  parameter int NV_CYCLES = 50
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic pauseN,
  input wire logic writeProtN,
  input wire logic addrSelectPin,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  input wire logic [pot_cmd_pkg::WIPER_W-1:0] wiperPositionCounter,
  input wire logic [pot_cmd_pkg::TAP_CNT-1:0] tapEnable,
  input wire logic writeBusy
);
  int busyCnt_q;
  // length of the current save, in mclk cycles
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busyCnt_q <= 0;
    end else begin
      busyCnt_q <= writeBusy ? busyCnt_q + 1 : 0;
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_tap_follow: assert property ($past(resetn) |-> tapEnable == (64'h1 << $past(wiperPositionCounter)))
    else $error("tap enables do not follow the wiper");
  a_out_hiz: assert property (chipSelN [*6] |-> serialOutEnN)
    else $error("output driven while deselected");
  a_en_selected: assert property ($fell(serialOutEnN) |-> !chipSelN)
    else $error("output enabled without select");
  a_out_falling: assert property ($changed(serialOut) && !serialOutEnN |-> !serialClk)
    else $error("output changed while serial clock high");
  a_busy_start: assert property ($rose(writeBusy) |-> chipSelN && writeProtN)
    else $error("save started while selected or protected");
  a_busy_hold: assert property ($rose(writeBusy) |=> writeBusy [*8])
    else $error("busy flag dropped early");
  a_busy_len: assert property ($fell(writeBusy) |-> busyCnt_q >= NV_CYCLES - 1 && busyCnt_q <= NV_CYCLES + 1)
    else $error("save length off");
  // wiper may only move inside a frame or while a transfer settles
  a_wiper_idle: assert property (chipSelN [*8] ##1 chipSelN [*8] ##1 chipSelN [*8] |=> $stable(wiperPositionCounter))
    else $error("wiper moved while deselected");
endmodule
bind pot_cmd_logic pot_cmd_logic_sva #(.NV_CYCLES(NV_CYCLES)) i_sva (.mclk(mclk), .resetn(resetn),
  .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .pauseN(pauseN), .writeProtN(writeProtN),
  .addrSelectPin(addrSelectPin), .serialOut(serialOut), .serialOutEnN(serialOutEnN),
  .wiperPositionCounter(wiperPositionCounter), .tapEnable(tapEnable), .writeBusy(writeBusy));
`default_nettype wire

// ### tb/spi_host_model.sv
// serial host model driving the command logic pins
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input wire logic mclk,
  input wire logic serialOut,
  input wire logic serialOutEnN,
  output logic chipSelN,
  output logic serialClk,
  output logic serialIn,
  output logic pauseN
);
  int pz = -1;
  // idle: deselected, clock parked low
  initial begin
    chipSelN = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
    pauseN = 1'b1;
  end
  // bits MSB first; r keeps the last eight bits sampled on rising clock
  task automatic frame(input logic [23:0] s, input int n, output logic [7:0] r);
    @(posedge mclk);
    #1;
    chipSelN = 1'b0;
    #80;
    for (int i = 23; i >= 24 - 8 * n; i--) begin
      if (i == pz) begin
        pauseN = 1'b0;
        #80;
        serialClk = 1'b1;
        #80;
        serialClk = 1'b0;
        #80;
        pauseN = 1'b1;
        #80;
      end
      serialIn = s[i];
      #80;
      // a released output reads back inverted, so a late or missing enable shows up
      r = {r[6:0], serialOutEnN ? ~serialOut : serialOut};
      serialClk = 1'b1;
      #80;
      serialClk = 1'b0;
    end
    #80;
    chipSelN = 1'b1;
    serialIn = ~serialIn; // released line must not look stable
    #240;
  endtask
endmodule
`default_nettype wire

// ### tb/pot_cmd_logic_test.sv
// self-checking bench for the potentiometer command logic
`timescale 1ns/1ns
`default_nettype none
module pot_cmd_logic_test;
  import pot_cmd_pkg::*;
  localparam int NV = 600;
  logic mclk, resetn, chipSelN, serialClk, serialIn, pauseN, writeProtN, addrPin, serialOut, serialOutEnN, writeBusy;
  logic [5:0] wiper;
  logic [63:0] taps;
  int failures = 0;
  int comparisons = 0;
  int st[4];
  int wip;
  int bz;

  pot_cmd_logic #(.NV_CYCLES(NV)) i_dut (.mclk(mclk), .resetn(resetn), .chipSelN(chipSelN), .serialClk(serialClk),
    .serialIn(serialIn), .pauseN(pauseN), .writeProtN(writeProtN), .addrSelectPin(addrPin), .serialOut(serialOut),
    .serialOutEnN(serialOutEnN), .wiperPositionCounter(wiper), .tapEnable(taps), .writeBusy(writeBusy));
  spi_host_model i_host (.mclk(mclk), .serialOut(serialOut), .serialOutEnN(serialOutEnN), .chipSelN(chipSelN),
    .serialClk(serialClk), .serialIn(serialIn), .pauseN(pauseN));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // settings come back as zero, so the wiper must too
  task automatic do_reset();
    resetn = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    resetn = 1'b1;
    st = '{0, 0, 0, 0};
    wip = 0;
    bz = 0;
    repeat (8) @(posedge mclk);
    #1;
    check({2'h0, wiper}, 8'(st[0]));
  endtask

  // one frame; bad flips the address bit, so nothing may change
  task automatic run(input logic [3:0] op, input logic [1:0] rs, input logic [7:0] d, input logic bad = 1'b0);
    logic [7:0] r;
    logic [1:0] lo;
    int n;
    lo = (op == OP_STATUS) ? LOW_BITS_STATUS : LOW_BITS_ZERO;
    n = (op == OP_SET_TO_WIPER || op == OP_WIPER_TO_SET) ? 2 : 3;
    i_host.frame({ID_TYPE_DEFAULT, ID_FIXED, addrPin ^ bad, op, rs, lo, d}, n, r);
    repeat (20) @(posedge mclk);
    #1;
    if (!bad) case (op)
      OP_RD_WIPER: check(r, 8'(wip));
      OP_RD_SET: check(r, 8'(st[rs]));
      OP_STATUS: check(r, 8'(bz));
      OP_WR_WIPER: wip = d[5:0];
      OP_SET_TO_WIPER: wip = st[rs];
      OP_INCDEC: for (int i = 7; i >= 0; i--) wip = d[i] ? (wip < 63 ? wip + 1 : 63) : (wip > 0 ? wip - 1 : 0);
      default: begin
        if (writeProtN && bz == 0) begin
          st[rs] = (op == OP_WR_SET) ? d[5:0] : wip;
          bz = 1;
        end
      end
    endcase
    check({2'h0, wiper}, 8'(wip));
    check({7'h0, writeBusy}, 8'(bz));
  endtask

  // busy seen by a status read, then waited out
  task automatic save(input logic [3:0] op, input logic [1:0] rs, input logic [7:0] d);
    run(op, rs, d);
    run(OP_STATUS, 2'h0, 8'h00);
    // look just after the edge, never in the step that launches the flag
    for (int k = 0; k < 2 * NV && writeBusy !== 1'b0; k++) begin
      @(posedge mclk);
      #1;
    end
    bz = 0;
    run(OP_STATUS, 2'h0, 8'h00);
  endtask

  initial begin
    resetn = 1'b0;
    writeProtN = 1'b1;
    void'($urandom(94));
    addrPin = 1'($urandom);
    do_reset();
    $display("end test reset");
    for (int i = 0; i < 4; i++) begin
      save(OP_WR_SET, 2'(i), {2'h0, 6'($urandom)});
      run(OP_RD_SET, 2'(i), 8'h00);
    end
    $display("end test settings");
    for (int i = 0; i < 4; i++) begin
      run(OP_SET_TO_WIPER, 2'(i), 8'h00);
      run(OP_RD_WIPER, 2'h0, 8'h00);
      run(OP_WR_WIPER, 2'h0, {2'h0, 6'($urandom)});
      save(OP_WIPER_TO_SET, 2'(i), 8'h00);
      run(OP_RD_SET, 2'(i), 8'h00);
    end
    $display("end test transfers");
    run(OP_WR_WIPER, 2'h0, 8'h3E);
    run(OP_INCDEC, 2'h0, 8'hFF);
    run(OP_WR_WIPER, 2'h0, 8'h02);
    run(OP_INCDEC, 2'h0, 8'h00);
    run(OP_INCDEC, 2'h0, 8'($urandom));
    $display("end test incdec");
    writeProtN = 1'b0;
    save(OP_WR_SET, 2'h1, 8'h2A);
    run(OP_WR_WIPER, 2'h0, 8'h11);
    run(OP_RD_SET, 2'h1, 8'h00);
    writeProtN = 1'b1;
    run(OP_WR_WIPER, 2'h0, 8'h15, 1'b1);
    i_host.pz = 12;
    run(OP_WR_WIPER, 2'h0, 8'h2C);
    i_host.pz = -1;
    $display("end test protect id pause");
    do_reset();
    run(OP_RD_SET, 2'h3, 8'h00);
    $display("end test second reset");
    print_verdict();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #900us;
    failures++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule
`default_nettype wire
